// >>> cuh_pkg.sv
// shared constants and types for the converter uart handshake block
package cuh_pkg;

	// integrate phase length, in internal clock periods
	localparam int unsigned INT_COUNT_16 = 32768;
	localparam int unsigned INT_COUNT_14 = 8192;
	// delay from run seen high to integrate start
	localparam int unsigned RUN_START_CLKS = 7;
	// least auto-zero length before a new conversion
	localparam int unsigned AZ_MIN_CLKS = 16;
	// conversion counter width, one bit above the widest count
	localparam int unsigned CNT_W = 17;
	localparam int unsigned MAG_W = 16;

	// bytes per handshake sequence
	localparam logic [1:0] BYTES_16 = 2'h3;
	localparam logic [1:0] BYTES_14 = 2'h2;

	// output byte lanes
	localparam logic [1:0] LANE_LOW  = 2'h0;
	localparam logic [1:0] LANE_MID  = 2'h1;
	localparam logic [1:0] LANE_HIGH = 2'h2;
	localparam int unsigned LANES = 3;

	// high byte field positions
	localparam int unsigned SIGN_POS = 7;
	localparam int unsigned OVR_POS  = 6;

	// byte fifo in the data path
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned FIFO_WIDTH = 10;

	// reset values
	localparam logic [7:0] DATA_RST   = 8'h00;
	localparam logic [2:0] LANE_OE_RST = 3'h7;

	typedef struct packed {
		logic             sign;
		logic             over;
		logic [MAG_W-1:0] mag;
	} cuh_result_type;

	typedef struct packed {
		logic [1:0] lane;
		logic [7:0] data;
	} cuh_lane_word_type;

	// enable terminals, all active low
	typedef struct packed {
		logic load_strobe_n;
		logic high_byte_sel_n;
		logic middle_byte_sel_n;
		logic low_byte_sel_n;
	} cuh_sel_pins_type;

	localparam cuh_sel_pins_type SEL_IDLE = 4'hf;

	typedef enum logic [1:0] {
		PH_AZ    = 2'b00,
		PH_START = 2'b01,
		PH_INT   = 2'b10,
		PH_DEINT = 2'b11
	} cuh_phase_type;

	typedef enum logic [2:0] {
		HS_IDLE    = 3'b000,
		HS_WAIT    = 3'b001,
		HS_ARM     = 3'b010,
		HS_STROBE  = 3'b011,
		HS_HELD    = 3'b100,
		HS_RELEASE = 3'b101
	} cuh_hs_type;

endpackage

// >>> cuh_fifo.sv
// byte fifo between result latch and handshake sequencer
`timescale 1ns/1ps
module cuh_fifo #(
	parameter int unsigned WIDTH = 10,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	logic             do_wr;
	logic             do_rd;

	assign in_ready  = (fill != (AW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	// pointers wrap at depth, which need not be a power of two
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (do_rd) begin
				rd_ptr <= bump(rd_ptr);
			end
			if (do_wr && !do_rd) begin
				fill <= fill + (AW+1)'(1);
			end else if (do_rd && !do_wr) begin
				fill <= fill - (AW+1)'(1);
			end
		end
	end

endmodule

// >>> cuh_handshake.sv
// converter digital core: conversion timing, result latch, uart handshake
`timescale 1ns/1ps
// What this block does
// - mode high plus latch enters handshake mode
// - sample send permit on internal falling edge
// - permit high: strobe, high select low
// - high byte holds sign, overrange; count bits in 14-bit only
// - strobe one period, data 1.5, select two
// - high, middle (16-bit only), low; then leave mode
// - permit low stalls with byte driven
// - permit back: data off, then next
// - leave mode half clock after last
// - every conversion handshakes while mode high, unless busy
// - mode rising edge starts one sequence
// - permit low at entry waits first
// - conversions continue, results discarded when busy
// - reset: auto-zero, result and mode clear
// - internal clock from oscillator pins
// - integrate lasts fixed count of periods
// - direct mode: enables are inputs
module cuh_handshake
	import cuh_pkg::*;
#(
	parameter bit          WIDE16   = 1'b1,
	parameter int unsigned INT_CLKS = WIDE16 ? INT_COUNT_16 : INT_COUNT_14,
	parameter int unsigned AZ_MIN   = AZ_MIN_CLKS
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	// oscillator pins and clock source strap
	input  wire logic                   osc1_pin,
	input  wire logic                   osc2_pin,
	input  wire logic                   ext_clk_sel,
	// converter control and comparator
	input  wire logic                   mode_pin,
	input  wire logic                   run_hold,
	input  wire logic                   zero_cross,
	input  wire logic                   comparator_sign,
	output cuh_phase_type               phase,
	output logic                        status,
	// handshake pacing
	input  wire logic                   send_permit,
	// enable terminals, two-way
	input  wire cuh_sel_pins_type       sel_in,
	output cuh_sel_pins_type            sel_out,
	output logic                        sel_oe_n,
	// byte data terminals
	output logic [LANES-1:0][7:0]       lane_data,
	output logic [LANES-1:0]            lane_oe_n
);
	localparam logic [1:0] NBYTES = WIDE16 ? BYTES_16 : BYTES_14;
	localparam int unsigned NSYNC = 12;

	// pin synchronisers
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic             s_osc1;
	logic             s_osc2;
	logic             s_ext;
	logic             s_mode;
	logic             s_run;
	logic             s_zero;
	logic             s_sign;
	logic             s_permit;
	cuh_sel_pins_type s_sel;

	// internal clock edges
	logic int_clk_q;
	logic int_clk_d;
	logic rise_en;
	logic fall_en;

	// conversion state
	logic [CNT_W-1:0] cnt;
	logic             sign_cap;
	logic             over_cap;
	logic [MAG_W-1:0] mag_cap;
	logic             deint_done;
	logic             latch_req;
	logic             latch_fire;
	logic             stat_drop;
	cuh_result_type   result;

	// handshake state
	cuh_hs_type        hs_state;
	logic              hs_active;
	logic              mode_d;
	logic              mode_arm;
	logic              enter;
	logic [1:0]        push_left;
	logic [1:0]        push_lane;
	cuh_lane_word_type push_word;
	cuh_lane_word_type pop_word;
	cuh_lane_word_type cur;
	logic              push_ready;
	logic              pop_valid;
	logic              pop;
	logic              last_byte;
	logic              drive_en;

	// byte lane contents of a result
	function automatic logic [7:0] byte_of(input cuh_result_type r, input logic [1:0] lane);
		logic [7:0] b;
		b = DATA_RST;
		unique case (lane)
			LANE_HIGH: begin
				b[SIGN_POS] = r.sign;
				b[OVR_POS]  = r.over;
				if (!WIDE16) begin
					b[5:0] = r.mag[13:8];
				end
			end
			LANE_MID: begin
				if (WIDE16) begin
					b = r.mag[15:8];
				end
			end
			LANE_LOW: begin
				b = r.mag[7:0];
			end
			default: begin
				b = DATA_RST;
			end
		endcase
		byte_of = b;
	endfunction

	// direct-mode select pin that matches a lane
	function automatic logic lane_sel_n(input cuh_sel_pins_type p, input logic [1:0] lane);
		unique case (lane)
			LANE_HIGH: lane_sel_n = p.high_byte_sel_n;
			LANE_MID:  lane_sel_n = p.middle_byte_sel_n;
			default:   lane_sel_n = p.low_byte_sel_n;
		endcase
	endfunction

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			// osc2 resets high so the internal clock shows no false edge
			sync1 <= {SEL_IDLE, 8'h48};
			sync2 <= {SEL_IDLE, 8'h48};
		end else begin
			sync1 <= {sel_in, osc1_pin, osc2_pin, ext_clk_sel, mode_pin,
				send_permit, run_hold, zero_cross, comparator_sign};
			sync2 <= sync1;
		end
	end

	assign {s_sel, s_osc1, s_osc2, s_ext, s_mode,
		s_permit, s_run, s_zero, s_sign} = sync2;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			int_clk_q <= 1'b0;
			int_clk_d <= 1'b0;
		end else begin
			int_clk_q <= s_ext ? s_osc1 : ~s_osc2;
			int_clk_d <= int_clk_q;
		end
	end

	// the pins run far slower than mclk, so edges become enables
	assign rise_en = int_clk_q & ~int_clk_d;
	assign fall_en = ~int_clk_q & int_clk_d;

	assign deint_done = rise_en && (phase == PH_DEINT)
		&& (s_zero || cnt == CNT_W'(INT_CLKS - 1));

	// conversion phase sequencer, on internal rising edges
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase    <= PH_AZ;
			cnt      <= '0;
			sign_cap <= 1'b0;
			over_cap <= 1'b0;
			mag_cap  <= '0;
		end else if (rise_en) begin
			unique case (phase)
				PH_AZ: begin
					if (cnt < CNT_W'(AZ_MIN)) begin
						cnt <= cnt + CNT_W'(1);
					end else if (s_run) begin
						phase <= PH_START;
						cnt   <= '0;
					end
				end
				PH_START: begin
					if (cnt == CNT_W'(RUN_START_CLKS - 1)) begin
						phase <= PH_INT;
						cnt   <= '0;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				PH_INT: begin
					if (cnt == CNT_W'(INT_CLKS - 1)) begin
						phase    <= PH_DEINT;
						cnt      <= '0;
						sign_cap <= s_sign;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				PH_DEINT: begin
					if (deint_done) begin
						phase    <= PH_AZ;
						cnt      <= '0;
						mag_cap  <= cnt[MAG_W-1:0];
						over_cap <= ~s_zero;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
			endcase
		end
	end

	// result latch on the falling edge after deintegrate ends
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			latch_req <= 1'b0;
		end else if (deint_done) begin
			latch_req <= 1'b1;
		end else if (fall_en) begin
			latch_req <= 1'b0;
		end
	end

	// no latching while a handshake runs
	assign latch_fire = fall_en & latch_req & ~hs_active;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			result <= '0;
		end else if (latch_fire) begin
			result <= '{sign: sign_cap, over: over_cap, mag: mag_cap};
		end
	end

	// status drops half a clock after the store
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			status    <= 1'b0;
			stat_drop <= 1'b0;
		end else begin
			if (fall_en && latch_req) begin
				stat_drop <= 1'b1;
			end else if (rise_en) begin
				stat_drop <= 1'b0;
			end
			if (rise_en && stat_drop) begin
				status <= 1'b0;
			end else if (rise_en && phase == PH_START
				&& cnt == CNT_W'(RUN_START_CLKS - 1)) begin
				status <= 1'b1;
			end
		end
	end

	// mode edge capture; ignored while a handshake runs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_d   <= 1'b0;
			mode_arm <= 1'b0;
		end else begin
			mode_d <= s_mode;
			if (enter) begin
				mode_arm <= 1'b0;
			end else if (s_mode && !mode_d && !hs_active) begin
				mode_arm <= 1'b1;
			end
		end
	end

	// entry after latch, or on demand
	assign enter = ~hs_active & ((latch_fire & s_mode) | (mode_arm & ~latch_req));

	// byte loader feeding the fifo, high byte first
	assign push_lane = (push_left == 2'h1) ? LANE_LOW
		: ((push_left == 2'h2 && WIDE16) ? LANE_MID : LANE_HIGH);
	assign push_word = '{lane: push_lane, data: byte_of(result, push_lane)};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			push_left <= 2'h0;
		end else if (enter) begin
			// two or three bytes per sequence
			push_left <= NBYTES;
		end else if (push_left != 2'h0 && push_ready) begin
			push_left <= push_left - 2'h1;
		end
	end

	// the sequencer only takes a byte once it has arrived
	cuh_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_valid  (push_left != 2'h0),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop),
		.out_data  (pop_word)
	);

	assign last_byte = (cur.lane == LANE_LOW);
	assign pop = rise_en & pop_valid
		& ((hs_state == HS_ARM) | ((hs_state == HS_RELEASE) & ~last_byte));

	// byte sequencer, paced by internal clock edges
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hs_state  <= HS_IDLE;
			hs_active <= 1'b0;
			cur       <= '0;
		end else begin
			if (pop) begin
				cur <= pop_word;
			end
			unique case (hs_state)
				HS_IDLE: begin
					if (enter) begin
						hs_active <= 1'b1;
						hs_state  <= (fall_en && s_permit) ? HS_ARM : HS_WAIT;
					end
				end
				HS_WAIT: begin
					// wait for permit before first byte
					if (fall_en && s_permit) begin
						hs_state <= HS_ARM;
					end
				end
				HS_ARM: begin
					if (pop) begin
						hs_state <= HS_STROBE;
					end
				end
				HS_STROBE: begin
					if (rise_en) begin
						hs_state <= HS_HELD;
					end
				end
				HS_HELD: begin
					if (fall_en && s_permit) begin
						hs_state <= HS_RELEASE;
					end
				end
				HS_RELEASE: begin
					if (rise_en) begin
						if (last_byte) begin
							hs_state  <= HS_IDLE;
							hs_active <= 1'b0;
						end else if (pop) begin
							hs_state <= HS_STROBE;
						end else begin
							hs_state <= HS_ARM;
						end
					end
				end
				default: begin
					hs_state  <= HS_IDLE;
					hs_active <= 1'b0;
				end
			endcase
		end
	end

	// terminals driven in handshake or mode high
	assign drive_en = s_mode | hs_active;

	// enable terminals, registered
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sel_out  <= SEL_IDLE;
			sel_oe_n <= 1'b1;
		end else begin
			sel_oe_n <= ~drive_en;
			sel_out.load_strobe_n <= (hs_state != HS_STROBE);
			sel_out.high_byte_sel_n   <= ~(hs_active && hs_state >= HS_STROBE
				&& cur.lane == LANE_HIGH);
			sel_out.middle_byte_sel_n <= ~(hs_active && hs_state >= HS_STROBE
				&& cur.lane == LANE_MID);
			sel_out.low_byte_sel_n    <= ~(hs_active && hs_state >= HS_STROBE
				&& cur.lane == LANE_LOW);
		end
	end

	// byte data terminals, registered; one mclk behind the sequencer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lane_data <= '0;
			lane_oe_n <= LANE_OE_RST;
		end else begin
			for (int l = 0; l < LANES; l++) begin
				if (hs_active) begin
					// data off at the permit edge
					lane_data[l] <= cur.data;
					lane_oe_n[l] <= ~((hs_state == HS_STROBE || hs_state == HS_HELD)
						&& cur.lane == 2'(l));
				end else begin
					// direct read under chip and byte select
					lane_data[l] <= byte_of(result, 2'(l));
					lane_oe_n[l] <= drive_en || s_sel.load_strobe_n
						|| lane_sel_n(s_sel, 2'(l)) || (!WIDE16 && 2'(l) == LANE_MID);
				end
			end
		end
	end

endmodule

// >>> cuh_handshake_props.sv
// property checker for the converter uart handshake pins
`timescale 1ns/1ps
module cuh_handshake_props
	import cuh_pkg::*;
(
	// clock and reset
	input wire logic             mclk,
	input wire logic             arst_n,
	// pins watched
	input wire logic             osc1_pin,
	input wire logic             osc2_pin,
	input wire logic             ext_clk_sel,
	input wire logic             send_permit,
	input wire cuh_sel_pins_type sel_in,
	input wire cuh_sel_pins_type sel_out,
	input wire logic             sel_oe_n,
	input wire logic [LANES-1:0] lane_oe_n
);
	logic       int_q;
	logic [1:0] rises;
	logic [7:0] plow;
	logic [2:0] bsel;
	logic       hs;
	logic       icl;
	assign icl  = ext_clk_sel ? osc1_pin : ~osc2_pin;
	assign hs   = ~sel_oe_n;
	assign bsel = {sel_out.high_byte_sel_n, sel_out.middle_byte_sel_n, sel_out.low_byte_sel_n};
	// raw internal rises while the strobe is low; lag stays well under a half period
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			int_q <= 1'b0;
			rises <= 2'h0;
		end else begin
			int_q <= icl;
			rises <= sel_out.load_strobe_n ? 2'h0 : rises + {1'b0, icl & ~int_q};
		end
	end
	// run length of a low permit, saturating
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			plow <= 8'h00;
		else
			plow <= send_permit ? 8'h00 : plow + {7'h00, plow != 8'hff};
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!arst_n);
	strobe_one_byte_a: assert property (
		$fell(sel_out.load_strobe_n) && hs |-> $countones(bsel) == 2 && lane_oe_n != 3'h7)
		else $error("strobe without a single byte select");
	strobe_period_a: assert property (
		$rose(sel_out.load_strobe_n) && hs |-> rises == 2'h1)
		else $error("strobe low not one internal period");
	load_data_a: assert property (
		$rose(sel_out.load_strobe_n) && hs |-> lane_oe_n != 3'h7)
		else $error("no byte driven at load edge");
	lane_with_sel_a: assert property (
		hs |-> (~lane_oe_n & bsel) == 3'h0)
		else $error("lane driven without its select");
	off_before_sel_a: assert property (
		hs && $rose(sel_out.high_byte_sel_n) |-> $past(lane_oe_n[2], 4))
		else $error("high lane not off half a clock before select");
	end_idle_a: assert property (
		hs && $rose(sel_out.low_byte_sel_n) |-> sel_out == SEL_IDLE && lane_oe_n == 3'h7)
		else $error("terminals not idle after last byte");
	stall_hold_a: assert property (
		hs && plow > 8'h28 |-> $stable(sel_out) && $stable(lane_oe_n))
		else $error("sequence moved while permit low");
	permit_gate_a: assert property (
		$fell(sel_out.load_strobe_n) && hs |-> plow < 8'h14)
		else $error("strobe without permit sensed");
	direct_lane_a: assert property (
		sel_oe_n && $past(sel_oe_n, 8) && sel_in == $past(sel_in, 8)
		|-> lane_oe_n == ({3{sel_in.load_strobe_n}} | {sel_in[2], sel_in[1], sel_in[0]}))
		else $error("direct mode lane enable wrong");
	cover property (hs && $rose(sel_out.low_byte_sel_n));
	cover property (hs && plow == 8'h29);
	cover property (sel_oe_n && lane_oe_n != 3'h7);
endmodule

bind cuh_handshake cuh_handshake_props u_cuh_handshake_props (
	.mclk(mclk), .arst_n(arst_n), .osc1_pin(osc1_pin), .osc2_pin(osc2_pin),
	.ext_clk_sel(ext_clk_sel), .send_permit(send_permit), .sel_in(sel_in),
	.sel_out(sel_out), .sel_oe_n(sel_oe_n), .lane_oe_n(lane_oe_n)
);

// >>> cuh_uart_buf.sv
// uart transmit buffer model facing the handshake pins
`timescale 1ns/1ps
module cuh_uart_buf
	import cuh_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  arst_n,
	// device pins, wire levels
	input  wire logic                  load_n,
	input  wire logic [2:0]            byte_sel_n,
	input  wire logic [LANES-1:0][7:0] lane_data,
	input  wire logic [LANES-1:0]      lane_oe_n,
	// drain time and a held-full buffer
	input  wire logic [7:0]            hold_clks,
	input  wire logic                  tx_busy,
	// empty flag and captured byte
	output logic                       send_permit,
	output logic                       rx_stb,
	output logic [7:0]                 rx_byte,
	output logic [2:0]                 rx_sel
);
	logic [7:0] bus;
	logic [7:0] last;
	logic [7:0] cnt;
	logic       load_q;
	logic       full;
	// a released bus shows the inverse of its last level, never a stale copy
	always_comb begin
		bus = ~last;
		for (int l = 0; l < LANES; l++)
			if (!lane_oe_n[l])
				bus = lane_data[l];
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			load_q <= 1'b1;
			full <= 1'b0;
			cnt <= 8'h00;
			last <= 8'h00;
			rx_stb <= 1'b0;
			rx_byte <= 8'h00;
			rx_sel <= 3'h7;
		end else begin
			load_q <= load_n;
			last <= bus;
			rx_stb <= 1'b0;
			// latch the bus on the strobe rising edge
			if (load_n && !load_q) begin
				full <= 1'b1;
				cnt <= hold_clks;
				rx_stb <= 1'b1;
				rx_byte <= bus;
				rx_sel <= byte_sel_n;
			end else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			else if (!tx_busy)
				full <= 1'b0;
		end
	end
	// permit is the empty flag, high whenever idle
	assign send_permit = !full && !tx_busy;
endmodule

// >>> tb_cuh_handshake.sv
// self-checking bench for the converter uart handshake block
`timescale 1ns/1ps
module tb_cuh_handshake;
	import cuh_pkg::*;
	logic                  mclk, arst_n, icl, ext_clk_sel, mode_pin, run_hold;
	logic                  zero_cross, comparator_sign, tx_busy, send_permit;
	logic                  sel_oe_n, status, rx_stb, st_q;
	logic [2:0]            div, rx_sel;
	logic [7:0]            hold_clks, rx_byte;
	cuh_phase_type         phase;
	cuh_sel_pins_type      dir_sel, sel_in, sel_out;
	logic [LANES-1:0][7:0] lane_data;
	logic [LANES-1:0]      lane_oe_n;
	logic [7:0]            bq[$];
	logic [2:0]            sq[$];
	int                    failures, check_count, st_hs, int_len, int_last;
	// wire level of the enable terminals from whichever side drives them
	assign sel_in = sel_oe_n ? dir_sel : sel_out;
	cuh_handshake #(.WIDE16(1'b1), .INT_CLKS(16), .AZ_MIN(2)) u_cuh_handshake (
		.mclk(mclk), .arst_n(arst_n), .osc1_pin(icl), .osc2_pin(~icl),
		.ext_clk_sel(ext_clk_sel), .mode_pin(mode_pin), .run_hold(run_hold),
		.zero_cross(zero_cross), .comparator_sign(comparator_sign), .phase(phase),
		.status(status), .send_permit(send_permit), .sel_in(sel_in), .sel_out(sel_out),
		.sel_oe_n(sel_oe_n), .lane_data(lane_data), .lane_oe_n(lane_oe_n)
	);
	cuh_uart_buf u_cuh_uart_buf (
		.mclk(mclk), .arst_n(arst_n), .load_n(sel_in.load_strobe_n),
		.byte_sel_n({sel_in.high_byte_sel_n, sel_in.middle_byte_sel_n, sel_in.low_byte_sel_n}),
		.lane_data(lane_data), .lane_oe_n(lane_oe_n), .hold_clks(hold_clks),
		.tx_busy(tx_busy), .send_permit(send_permit), .rx_stb(rx_stb), .rx_byte(rx_byte),
		.rx_sel(rx_sel)
	);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// internal clock of 16 mclk periods
	always @(posedge mclk) begin
		div <= div + 3'h1;
		if (div == 3'h7)
			icl <= ~icl;
	end
	always @(posedge mclk) begin
		st_q <= status;
		if (phase == PH_INT)
			int_len <= int_len + 1;
		else if (int_len != 0) begin
			int_last <= int_len;
			int_len <= 0;
		end
		// status starting while a handshake runs
		if (status && !st_q && sel_out !== SEL_IDLE)
			st_hs++;
		if (rx_stb) begin
			bq.push_back(rx_byte);
			sq.push_back(rx_sel);
		end
	end
	task check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task wait_bytes(input int n);
		for (int k = 0; k < 20000 && bq.size() < n; k++)
			@(posedge mclk);
		check(bq.size() >= n, "bytes missing");
	endtask
	task check_seq(input int i, input logic over);
		check(sq[i] === 3'h3 && sq[i+1] === 3'h5 && sq[i+2] === 3'h6, "byte order");
		check(bq[i][7:6] === {comparator_sign, over}, "sign or overrange");
		check(bq[i][5:0] === 6'h00 && bq[i+1] === 8'h00, "upper count bits");
		check(bq[i+2] === (over ? 8'h0f : 8'h00), "low count byte");
	endtask
	task t_reset;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		#1;
		check(phase === PH_AZ && status === 1'b0, "phase after reset");
		check(sel_oe_n === 1'b1 && sel_out === SEL_IDLE, "mode after reset");
		check(lane_oe_n === 3'h7, "lanes after reset");
		@(posedge mclk);
	endtask
	task t_demand;
		tx_busy <= 1'b1;
		mode_pin <= 1'b1;
		repeat (40) @(posedge mclk);
		mode_pin <= 1'b0;
		repeat (300) @(posedge mclk);
		check(bq.size() == 0 && sel_oe_n === 1'b0, "load before permit");
		tx_busy <= 1'b0;
		wait_bytes(3);
		check(sq[0] === 3'h3 && sq[1] === 3'h5 && sq[2] === 3'h6, "demand order");
		repeat (60) @(posedge mclk);
		check(sel_oe_n === 1'b1 && lane_oe_n === 3'h7, "release after demand");
	endtask
	task t_stream;
		bq.delete();
		sq.delete();
		zero_cross <= 1'b1;
		comparator_sign <= 1'b1;
		mode_pin <= 1'b1;
		wait_bytes(3);
		run_hold <= 1'b1;
		wait_bytes(9);
		check(sel_oe_n === 1'b0, "terminals not driven in mode");
		check(int_last == 16 * 16, "integrate length");
		check_seq(3, 1'b0);
		check_seq(6, 1'b0);
	endtask
	task t_stall;
		int i;
		zero_cross <= 1'b0;
		comparator_sign <= 1'b0;
		hold_clks <= 8'hc8;
		ext_clk_sel <= 1'b1;
		repeat (1500) @(posedge mclk);
		bq.delete();
		sq.delete();
		st_hs = 0;
		wait_bytes(6);
		i = (sq[0] === 3'h3) ? 0 : (sq[1] === 3'h3) ? 1 : 2;
		check_seq(i, 1'b1);
		check(st_hs > 0, "conversions stopped in handshake");
	endtask
	task t_direct;
		logic [3:0] pat [4];
		logic [2:0] expv [4];
		pat = '{4'h6, 4'h3, 4'h5, 4'h8};
		expv = '{3'h6, 3'h3, 3'h5, 3'h7};
		mode_pin <= 1'b0;
		for (int k = 0; k < 3000 && sel_oe_n !== 1'b1; k++)
			@(posedge mclk);
		for (int k = 0; k < 4; k++) begin
			dir_sel <= pat[k];
			repeat (10) @(posedge mclk);
			check(lane_oe_n === expv[k], "direct lane enable");
		end
		check(lane_data === {8'h40, 8'h00, 8'h0f}, "direct data");
		dir_sel <= SEL_IDLE;
	endtask
	task results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		results();
	end
	initial begin
		arst_n = 1'b0;
		icl = 1'b0;
		div = 3'h0;
		ext_clk_sel = 1'b0;
		mode_pin = 1'b0;
		run_hold = 1'b0;
		zero_cross = 1'b0;
		comparator_sign = 1'b0;
		tx_busy = 1'b0;
		hold_clks = 8'h04;
		dir_sel = SEL_IDLE;
		t_reset();
		t_demand();
		t_stream();
		t_stall();
		t_direct();
		results();
	end
endmodule
